// >>> sms_pkg.sv
// shared constants and carrier types for the spi master/slave core
package sms_pkg;

    // bus clock
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned CLK_PERIOD_NS = 50;

    // sclk target rate; the divisor is even, so one half period is whole
    localparam int unsigned SCLK_TARGET_HZ = 1_000_000;
    // half period of sclk in bus clocks, rounded up so sclk never exceeds
    // the target
    localparam int unsigned SCLK_HALF_CYC =
        (CLK_HZ + 2 * SCLK_TARGET_HZ - 1) / (2 * SCLK_TARGET_HZ);

    // wait between select and first sclk edge, 0 still leaves one half period
    localparam int unsigned SEL_DELAY_NS = 0;

    // build-time defaults
    localparam int unsigned DATA_WIDTH  = 8;
    localparam int unsigned NUM_SELECTS = 16;

    // reset values
    localparam logic [15:0] SEL_IDLE = 16'hffff;

    // master sequencer states, one-hot
    typedef enum logic [2:0] {
        SMS_M_IDLE = 3'h1,
        SMS_M_LEAD = 3'h2,
        SMS_M_XFER = 3'h4
    } sms_mstate_t;

    // host enables for the interrupt sources
    typedef struct packed {
        logic rx_ie;
        logic tx_ie;
    } sms_ctrl_t;

    // status view of the core
    typedef struct packed {
        logic rx_overrun;
        logic rx_full;
        logic tx_empty;
        logic busy;
    } sms_status_t;

endpackage : sms_pkg

// >>> sms_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module sms_sync #(
    parameter int unsigned   W       = 1,
    parameter logic [W-1:0]  RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] q_d;

    // a bit only changes once stages two and three agree
    assign q_d = (s2_q & s3_q) | (q & (s2_q ^ s3_q));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            q    <= RST_VAL;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q    <= q_d;
        end
    end
endmodule // sms_sync
`default_nettype wire

// >>> sms_tick.sv
// half-period tick generator for the master sclk
`timescale 1ns/1ns
`default_nettype none
module sms_tick #(
    parameter int unsigned HALF = 10
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic run,
    output logic      tick
);
    // a zero half period has no count to run
    if (HALF < 1) begin : g_bad_half
        $error("half period must be at least one clock");
    end
    localparam int unsigned CW = $clog2(HALF + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF - 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          wrap;

    // restart while stopped so the first half period is always whole
    assign wrap  = run && (cnt_q == LAST);
    assign cnt_d = (!run || wrap) ? '0 : cnt_q + CW'(1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick  <= wrap;
        end
    end
endmodule // sms_tick
`default_nettype wire

// >>> sms_core.sv
// spi core, master or slave by build-time parameter
//
// Function
// - role is a build-time parameter, never changed at run time
// - holding and shift registers share one width, 1 to 16 bits
// - host word in transmit holding goes to shifter, sent next transfer
// - transmit double-buffered; holding moves to shifter when not shifting
// - transmit shifter drives mosi as master, miso as slave
// - build-time bit order for both transmit and receive shifters
// - completed shift copies whole receive shifter into receive holding
// - receive shifter fed from miso as master, mosi as slave
// - only master starts; host write to transmit holding starts it
// - enabled interrupts for word received and transmit holding free
// - full duplex; one new bit each way on each active edge
// - master sclk made by dividing the bus clock
// - master has one select per slave, asserts chosen ones during transfer
// - select lines active low, both driving and watching
// - slave watches select, starts shifting once the synchronised select goes low, about four clocks after the pin
// - slave sends host word on next transfer the master starts
// - all logic on bus clock; slave capture follows incoming sclk
// - status readable at any time shows transfer progress
// - clock polarity sets sclk idle level
// - clock phase picks leading or trailing sample edge
// - optional select-to-sclk wait, rounded up to half periods
`timescale 1ns/1ns
`default_nettype none
module sms_core #(
    parameter bit          IS_MASTER = 1'b1,
    parameter int unsigned WIDTH     = sms_pkg::DATA_WIDTH,
    parameter bit          LSB_FIRST = 1'b0,
    parameter bit          CPOL      = 1'b0,
    parameter bit          CPHA      = 1'b0,
    parameter int unsigned NUM_SEL   = sms_pkg::NUM_SELECTS,
    parameter int unsigned HALF_CYC  = sms_pkg::SCLK_HALF_CYC,
    parameter int unsigned DELAY_NS  = sms_pkg::SEL_DELAY_NS
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                tx_wr,
    input  wire logic [WIDTH-1:0]    tx_wdata,
    input  wire logic                rx_rd,
    input  wire logic [NUM_SEL-1:0]  sel_mask,
    input  wire sms_pkg::sms_ctrl_t  ctrl,
    output logic      [WIDTH-1:0]    rx_data,
    output sms_pkg::sms_status_t     status,
    output logic                     irq,
    output logic                     sclk_o,
    output logic                     mosi_o,
    output logic      [NUM_SEL-1:0]  select_out_m,
    input  wire logic                sclk_i,
    input  wire logic                mosi_i,
    input  wire logic                miso_i,
    input  wire logic                select_in_n,
    output logic                     miso_o,
    output logic                     miso_oe_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
        $error("data width must be 1 to 16");
    end
    if (NUM_SEL < 1 || NUM_SEL > 16) begin : g_bad_sel
        $error("select count must be 1 to 16");
    end
    // synchronised miso lags about four clocks; it must settle by the edge
    if (HALF_CYC < 5) begin : g_bad_half
        $error("sclk half period must be at least 5 bus clocks");
    end

    localparam int unsigned HALF_NS = HALF_CYC * sms_pkg::CLK_PERIOD_NS;
    // wait rounded up to whole half periods, at least one
    localparam int unsigned LEAD_RAW = (DELAY_NS + HALF_NS - 1) / HALF_NS;
    localparam int unsigned LEAD_N   = (LEAD_RAW < 1) ? 1 : LEAD_RAW;
    localparam int unsigned LW       = $clog2(LEAD_N + 1);
    localparam logic [LW-1:0] LEAD_LAST = LW'(LEAD_N - 1);
    localparam logic [4:0]    EDGE_LAST = 5'(2 * WIDTH - 1);
    localparam logic [4:0]    BITS      = 5'(WIDTH);

    // bit-order helpers shared by both shifters
    function automatic logic first_bit(input logic [WIDTH-1:0] v);
        return LSB_FIRST ? v[0] : v[WIDTH-1];
    endfunction
    function automatic logic [WIDTH-1:0] shift_out(
        input logic [WIDTH-1:0] v);
        return LSB_FIRST ? (v >> 1) : (v << 1);
    endfunction
    function automatic logic [WIDTH-1:0] shift_in(
        input logic [WIDTH-1:0] v, input logic b);
        logic [WIDTH-1:0] r;
        r = LSB_FIRST ? (v >> 1) : (v << 1);
        if (LSB_FIRST) begin
            r[WIDTH-1] = b;
        end else begin
            r[0] = b;
        end
        return r;
    endfunction

    // pins through the synchroniser; idle levels at reset
    logic [3:0] pin_s;
    sms_sync #(
        .W       (4),
        .RST_VAL ({1'b1, CPOL, 2'b00})
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({select_in_n, sclk_i, mosi_i, miso_i}),
        .q     (pin_s)
    );
    wire sel_act = !pin_s[3];
    wire sclk_s  = pin_s[2];
    wire mosi_s  = pin_s[1];
    wire miso_s  = pin_s[0];

    sms_pkg::sms_mstate_t state_q, state_d;
    logic                 tick;
    logic [LW-1:0]        lead_q, lead_d;
    logic [4:0]           edge_q, edge_d;
    logic                 sclk_q, sclk_d;
    logic [NUM_SEL-1:0]   sel_q, sel_d;
    logic [WIDTH-1:0]     tx_hold_q, tx_hold_d, tx_sh_q, tx_sh_d, tx_src;
    logic [WIDTH-1:0]     rx_sh_q, rx_sh_d, rx_hold_q, rx_hold_d;
    logic                 tx_empty_q, tx_empty_d;
    logic                 rx_full_q, rx_full_d, ovr_q, ovr_d;
    logic                 dout_q, dout_d;
    logic                 sel_prev_q, sclk_prev_q;
    logic [4:0]           scnt_q, scnt_d;
    logic                 oe_n_q, irq_q;
    sms_pkg::sms_status_t stat_q, stat_d;

    sms_tick #(
        .HALF (HALF_CYC)
    ) u_tick (
        .clk   (clk),
        .rst_n (rst_n),
        .run   (IS_MASTER && state_q != sms_pkg::SMS_M_IDLE),
        .tick  (tick)
    );

    // master edge decode; even edge count is the leading edge
    wire m_idle  = state_q == sms_pkg::SMS_M_IDLE;
    wire m_xfer  = state_q == sms_pkg::SMS_M_XFER;
    wire m_edge  = m_xfer && tick;
    wire m_lead  = !edge_q[0];
    wire m_last  = edge_q == EDGE_LAST;
    // write to holding starts a master transfer
    wire m_start = IS_MASTER && m_idle && !tx_empty_q;

    // slave edge decode from the synchronised sclk
    wire s_rise  = sel_act && !sel_prev_q;
    wire s_edge  = sel_act && sel_prev_q && (sclk_s != sclk_prev_q);
    wire s_lead  = sclk_s != CPOL;
    wire s_left  = scnt_q < BITS;

    // sample on leading edge for phase 0, trailing for phase 1
    wire sample  = IS_MASTER ? (m_edge && (m_lead ^ CPHA))
                             : (s_edge && (s_lead ^ CPHA) && s_left);
    // launch a new bit on the other edge of each pair
    wire m_launch = m_start ? !CPHA
                  : (m_edge && (CPHA ? m_lead : (!m_lead && !m_last)));
    wire s_launch = (s_rise && !CPHA)
                  || (s_edge && s_left && (CPHA ? s_lead : !s_lead));
    wire launch   = IS_MASTER ? m_launch : s_launch;
    // shifter reloads only while no shift runs
    wire load_sh  = IS_MASTER ? m_start : (!sel_act && !tx_empty_q);
    wire done     = IS_MASTER ? (m_edge && m_last)
                              : (sample && scnt_q == BITS - 5'(1));
    wire din      = IS_MASTER ? miso_s : mosi_s;

    // master sequencer
    always_comb begin
        state_d = state_q;
        lead_d  = lead_q;
        edge_d  = edge_q;
        sclk_d  = sclk_q;
        unique case (state_q)
            sms_pkg::SMS_M_IDLE: begin
                lead_d = '0;
                edge_d = '0;
                if (m_start) begin
                    state_d = sms_pkg::SMS_M_LEAD;
                end
            end
            // select held before the first edge
            sms_pkg::SMS_M_LEAD: begin
                if (tick) begin
                    lead_d = lead_q + LW'(1);
                    if (lead_q == LEAD_LAST) begin
                        state_d = sms_pkg::SMS_M_XFER;
                    end
                end
            end
            // divided sclk toggles on every half-period tick
            sms_pkg::SMS_M_XFER: begin
                if (tick) begin
                    sclk_d = !sclk_q;
                    edge_d = edge_q + 5'(1);
                    if (m_last) begin
                        state_d = sms_pkg::SMS_M_IDLE;
                    end
                end
            end
            default: begin
                state_d = sms_pkg::SMS_M_IDLE;
            end
        endcase
    end

    // chosen selects low during a transfer
    assign sel_d = (IS_MASTER && state_d != sms_pkg::SMS_M_IDLE)
                 ? ~sel_mask : {NUM_SEL{1'b1}};
    assign scnt_d = s_rise ? '0 : (sample ? scnt_q + 5'(1) : scnt_q);

    // shifter takes the held word; its first bit drives the pin
    assign tx_src  = load_sh ? tx_hold_q : tx_sh_q;
    assign tx_sh_d = launch ? shift_out(tx_src) : tx_src;
    assign dout_d  = launch ? first_bit(tx_src) : dout_q;
    // new writes overwrite the holding word; a write wins over the reload that empties it
    assign tx_hold_d  = tx_wr ? tx_wdata : tx_hold_q;
    assign tx_empty_d = !tx_wr && (tx_empty_q || load_sh);

    // whole word copied to holding only at completion
    assign rx_sh_d   = sample ? shift_in(rx_sh_q, din) : rx_sh_q;
    assign rx_hold_d = done ? rx_sh_d : rx_hold_q;
    assign rx_full_d = done || (rx_full_q && !rx_rd);
    assign ovr_d     = (done && rx_full_q && !rx_rd) || (ovr_q && !rx_rd);

    assign stat_d = '{rx_overrun: ovr_d, rx_full: rx_full_d,
                      tx_empty: tx_empty_d,
                      busy: IS_MASTER ? (state_d != sms_pkg::SMS_M_IDLE)
                                      : sel_act};

    // idle after reset, sclk at polarity level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= sms_pkg::SMS_M_IDLE;
            lead_q  <= '0;
            edge_q  <= '0;
            sclk_q  <= CPOL;
            sel_q   <= sms_pkg::SEL_IDLE[NUM_SEL-1:0];
        end else begin
            state_q <= state_d;
            lead_q  <= lead_d;
            edge_q  <= edge_d;
            sclk_q  <= sclk_d;
            sel_q   <= sel_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_hold_q  <= '0;
            tx_sh_q    <= '0;
            tx_empty_q <= 1'b1;
            dout_q     <= 1'b0;
            rx_sh_q    <= '0;
            rx_hold_q  <= '0;
            rx_full_q  <= 1'b0;
            ovr_q      <= 1'b0;
        end else begin
            tx_hold_q  <= tx_hold_d;
            tx_sh_q    <= tx_sh_d;
            tx_empty_q <= tx_empty_d;
            dout_q     <= dout_d;
            rx_sh_q    <= rx_sh_d;
            rx_hold_q  <= rx_hold_d;
            rx_full_q  <= rx_full_d;
            ovr_q      <= ovr_d;
        end
    end

    // slave tracks select and sclk edges continuously
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_prev_q  <= 1'b0;
            sclk_prev_q <= CPOL;
            scnt_q      <= '0;
            oe_n_q      <= 1'b1;
            irq_q       <= 1'b0;
            stat_q      <= '{rx_overrun: 1'b0, rx_full: 1'b0,
                             tx_empty: 1'b1, busy: 1'b0};
        end else begin
            sel_prev_q  <= sel_act;
            sclk_prev_q <= sclk_s;
            scnt_q      <= scnt_d;
            oe_n_q      <= IS_MASTER || !sel_act;
            // enabled sources onto the interrupt line
            irq_q       <= (ctrl.rx_ie && rx_full_d)
                        || (ctrl.tx_ie && tx_empty_d);
            stat_q      <= stat_d;
        end
    end

    // role fixed by parameter; unused role outputs rest constant
    assign sclk_o       = IS_MASTER ? sclk_q : CPOL;
    assign mosi_o       = IS_MASTER ? dout_q : 1'b0;
    assign miso_o       = IS_MASTER ? 1'b0 : dout_q;
    assign miso_oe_n    = oe_n_q;
    assign select_out_m = sel_q;
    assign rx_data      = rx_hold_q;
    assign status       = stat_q;
    assign irq          = irq_q;

    property p_sclk_idle;
        (IS_MASTER && m_idle && $past(m_idle)) |-> sclk_o == CPOL;
    endproperty
    a_sclk_idle: assert property (p_sclk_idle)
        else $error("sclk not at idle level");
    property p_sel_idle;
        (m_idle && $past(m_idle)) |-> &select_out_m;
    endproperty
    a_sel_idle: assert property (p_sel_idle)
        else $error("select asserted while idle");
    property p_sel_xfer;
        (IS_MASTER && m_xfer && $past(m_xfer))
            |-> select_out_m == ~$past(sel_mask);
    endproperty
    a_sel_xfer: assert property (p_sel_xfer)
        else $error("select lines differ from mask during transfer");
    property p_sclk_toggle;
        (IS_MASTER && m_edge) |=> sclk_o != $past(sclk_o);
    endproperty
    a_sclk_toggle: assert property (p_sclk_toggle)
        else $error("sclk did not toggle on tick");
    property p_tx_take;
        tx_wr |=> !status.tx_empty ##0 !tx_empty_q;
    endproperty
    a_tx_take: assert property (p_tx_take)
        else $error("written word not held");
    property p_rx_copy;
        done |=> rx_full_q && rx_data == $past(rx_sh_d);
    endproperty
    a_rx_copy: assert property (p_rx_copy)
        else $error("received word not copied on completion");
    property p_rx_keep;
        !done |=> $stable(rx_data);
    endproperty
    a_rx_keep: assert property (p_rx_keep)
        else $error("receive holding changed mid-transfer");
    property p_len;
        (IS_MASTER && $rose(m_xfer))
            |-> (!done)[*2] ##1 (m_xfer || done);
    endproperty
    a_len: assert property (p_len)
        else $error("master transfer ended too early");
    property p_slave_oe;
        (!IS_MASTER && sel_act) |=> !miso_oe_n;
    endproperty
    a_slave_oe: assert property (p_slave_oe)
        else $error("slave not driving miso when selected");
    property p_irq;
        (ctrl.rx_ie && rx_full_d) |=> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("receive interrupt missing");
    c_master_done: cover property (IS_MASTER && done);
    c_slave_done: cover property (!IS_MASTER && done);
    c_overrun: cover property ($rose(ovr_q));

endmodule // sms_core
`default_nettype wire

// >>> sms_peer_model.sv
// behavioural off-chip spi slave, mode 0, msb first
`timescale 1ns/1ns
`default_nettype none
module sms_peer_model (
    input  wire logic       sclk,
    input  wire logic       mosi,
    input  wire logic       sel_n,
    input  wire logic [7:0] tx_word,
    output logic            miso,
    output logic      [7:0] rx_word
);
    logic [7:0] sh;
    initial begin
        miso <= 1'b0;
        sh = 8'h00;
        rx_word = 8'h00;
    end
    always @(negedge sel_n) begin
        sh = tx_word;
        miso <= tx_word[7];
    end
    always @(posedge sclk) if (!sel_n) rx_word = {rx_word[6:0], mosi};
    always @(negedge sclk) if (!sel_n) begin
        sh = {sh[6:0], 1'b0};
        miso <= sh[7];
    end
    // floating, no pull: show the inverse, not the last bit
    always @(posedge sel_n) miso <= ~miso;
endmodule // sms_peer_model
`default_nettype wire

// >>> spi_master_slave_core_test.sv
// self-checking bench for the core in master role with one peer slave, and in slave role driven by the bench
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
    miscompares++; $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
    end end
module spi_master_slave_core_test;
    logic                 clk = 1'b0;
    logic                 rst_n = 1'b0;
    logic                 tx_wr = 1'b0;
    logic                 rx_rd = 1'b0;
    logic                 miso;
    logic [7:0]           tx_wdata = 8'h00;
    logic [7:0]           ptx = 8'h00;
    logic [7:0]           prx;
    logic [7:0]           rx_data;
    logic [15:0]          sel_mask = 16'h0001;
    logic [15:0]          sel_n;
    logic                 irq;
    logic                 sclk;
    logic                 mosi;
    logic                 s_wr = 1'b0;
    logic                 s_rd = 1'b0;
    logic                 s_sel_n = 1'b1;
    logic                 s_sclk = 1'b0;
    logic                 s_mosi = 1'b0;
    logic [7:0]           s_wdata = 8'h00;
    logic [7:0]           s_rx;
    logic                 s_miso;
    logic                 s_oe_n;
    sms_pkg::sms_status_t s_status;
    sms_pkg::sms_ctrl_t   ctrl = 2'h0;
    sms_pkg::sms_status_t status;
    int                   miscompares = 0;
    int                   n_checks = 0;
    int                   psel = 0;

    always #25 clk = ~clk;

    // slave pins unused in master role, so held idle
    sms_core dut_u (
        .clk(clk), .rst_n(rst_n), .tx_wr(tx_wr), .tx_wdata(tx_wdata),
        .rx_rd(rx_rd), .sel_mask(sel_mask), .ctrl(ctrl), .rx_data(rx_data),
        .status(status), .irq(irq), .sclk_o(sclk), .mosi_o(mosi),
        .select_out_m(sel_n), .sclk_i(1'b0), .mosi_i(1'b0), .miso_i(miso),
        .select_in_n(1'b1), .miso_o(), .miso_oe_n()
    );
    sms_peer_model peer_u (
        .sclk(sclk), .mosi(mosi), .sel_n(sel_n[psel]), .tx_word(ptx),
        .miso(miso), .rx_word(prx)
    );
    // slave-role copy; the bench plays the external master on its pins
    sms_core #(
        .IS_MASTER (1'b0)
    ) dut_slave_u (
        .clk(clk), .rst_n(rst_n), .tx_wr(s_wr), .tx_wdata(s_wdata),
        .rx_rd(s_rd), .sel_mask(16'h0000), .ctrl(ctrl), .rx_data(s_rx),
        .status(s_status), .irq(), .sclk_o(), .mosi_o(), .select_out_m(),
        .sclk_i(s_sclk), .mosi_i(s_mosi), .miso_i(1'b0),
        .select_in_n(s_sel_n), .miso_o(s_miso), .miso_oe_n(s_oe_n)
    );

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // bounded wait for the chosen select line to reach a level
    task automatic wait_sel(input logic lvl);
        int i;
        i = 0;
        while (sel_n[psel] !== lvl && i < 1000) begin
            @(negedge clk);
            i++;
        end
        if (i == 1000) begin
            miscompares++;
            $display("CHECK FAILED select wait exp %h got %h", lvl, 1'bx);
            test_done();
        end
    endtask

    task automatic start(input logic [7:0] w);
        @(negedge clk);
        tx_wdata = w;
        tx_wr = 1'b1;
        @(negedge clk);
        tx_wr = 1'b0;
    endtask

    task automatic pulse_rd;
        @(negedge clk);
        rx_rd = 1'b1;
        @(negedge clk);
        rx_rd = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    task automatic t_reset;
        `CHK("sclk idle", 1'b0, sclk)
        `CHK("selects idle", 16'hffff, sel_n)
        `CHK("status", 4'h2, status)
        `CHK("rx_data", 8'h00, rx_data)
        `CHK("irq", 1'b0, irq)
        `CHK("slave oe idle", 1'b1, s_oe_n)
        $display("test reset done");
    endtask

    task automatic t_single;
        ptx = 8'h3c;
        ctrl = 2'h2;
        start(8'ha5);
        wait_sel(1'b0);
        `CHK("select", ~sel_mask, sel_n)
        `CHK("busy", 1'b1, status.busy)
        wait_sel(1'b1);
        `CHK("peer rx", 8'ha5, prx)
        repeat (3) @(negedge clk);
        `CHK("rx_data", 8'h3c, rx_data)
        `CHK("rx_full", 1'b1, status.rx_full)
        `CHK("irq rx", 1'b1, irq)
        pulse_rd();
        `CHK("rx_full clr", 1'b0, status.rx_full)
        `CHK("irq clr", 1'b0, irq)
        $display("test single done");
    endtask

    task automatic t_b2b;
        ptx = 8'h81;
        start(8'h5a);
        wait_sel(1'b0);
        ptx = 8'h7e;
        // second word written during the first transfer's select lead, before its first sclk edge
        start(8'hc3);
        @(negedge clk);
        `CHK("tx held", 1'b0, status.tx_empty)
        `CHK("rx old", 8'h3c, rx_data)
        wait_sel(1'b1);
        `CHK("peer rx1", 8'h5a, prx)
        `CHK("rx1", 8'h81, rx_data)
        wait_sel(1'b0);
        wait_sel(1'b1);
        `CHK("peer rx2", 8'hc3, prx)
        repeat (3) @(negedge clk);
        `CHK("rx2", 8'h7e, rx_data)
        `CHK("overrun", 1'b1, status.rx_overrun)
        `CHK("tx free", 1'b1, status.tx_empty)
        pulse_rd();
        $display("test b2b done");
    endtask

    task automatic t_sel;
        psel = 3;
        sel_mask = 16'h0008;
        ptx = 8'hf0;
        ctrl = 2'h1;
        repeat (3) @(negedge clk);
        `CHK("irq tx free", 1'b1, irq)
        start(8'h0f);
        wait_sel(1'b0);
        `CHK("select 3", 16'hfff7, sel_n)
        wait_sel(1'b1);
        `CHK("peer rx", 8'h0f, prx)
        repeat (3) @(negedge clk);
        `CHK("rx_data", 8'hf0, rx_data)
        `CHK("all off", 16'hffff, sel_n)
        ctrl = 2'h0;
        repeat (3) @(negedge clk);
        `CHK("irq masked", 1'b0, irq)
        pulse_rd();
        $display("test select done");
    endtask

    // bench acts as a mode 0 msb-first master, 8 clocks per half period
    task automatic t_slave;
        logic [7:0] got;
        logic [7:0] mw;
        int         b;
        got = 8'h00;
        mw = 8'h4b;
        @(negedge clk);
        s_wdata = 8'h96;
        s_wr = 1'b1;
        @(negedge clk);
        s_wr = 1'b0;
        repeat (3) @(negedge clk);
        `CHK("slave tx moved", 1'b1, s_status.tx_empty)
        s_sel_n = 1'b0;
        for (b = 7; b >= 0; b--) begin
            s_mosi = mw[b];
            repeat (8) @(negedge clk);
            got = {got[6:0], s_miso};
            s_sclk = 1'b1;
            repeat (8) @(negedge clk);
            s_sclk = 1'b0;
        end
        `CHK("slave oe", 1'b0, s_oe_n)
        `CHK("slave busy", 1'b1, s_status.busy)
        repeat (4) @(negedge clk);
        s_sel_n = 1'b1;
        repeat (8) @(negedge clk);
        `CHK("slave miso", 8'h96, got)
        `CHK("slave rx", 8'h4b, s_rx)
        `CHK("slave full", 1'b1, s_status.rx_full)
        `CHK("slave oe off", 1'b1, s_oe_n)
        s_rd = 1'b1;
        @(negedge clk);
        s_rd = 1'b0;
        $display("test slave done");
    endtask

    initial begin
        repeat (20) @(negedge clk);
        t_reset();
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        t_single();
        t_b2b();
        t_sel();
        t_slave();
        test_done();
    end
endmodule // spi_master_slave_core_test
`default_nettype wire
